// file: rtl/acd_pkg.sv
package acd_pkg;

	// ----------------------------------------------------------------
	// Register map and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CH4_EVEN  = 8'h14;
	localparam logic [7:0]  ADDR_PAT_HPF   = 8'h15;
	localparam logic [7:0]  ADDR_CTRL      = 8'h16;
	localparam logic [7:0]  ADDR_INSEL_PAT = 8'h17;
	localparam logic [15:0] REG_RESET      = 16'h0000;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// Datapath sizes and limits
	// ----------------------------------------------------------------
	localparam int SAMP_W    = 14;
	localparam int GAIN_FRAC = 12;
	localparam int HPF_FRAC  = 10;
	localparam int HPF_ACC_W = 26;
	localparam logic [3:0] K_MIN = 4'h2;
	localparam logic [3:0] K_MAX = 4'ha;
	localparam logic signed [31:0] SAMP_MAX = 32'sh00001fff;
	localparam logic signed [31:0] SAMP_MIN = -32'sh00002000;
	localparam logic signed [HPF_ACC_W-1:0] HPF_HALF = 26'sh0000200;
	localparam logic [13:0] GAIN_UNITY = 14'h1000;

	// Gain factors in steps of 0.2 dB, unsigned Q2.12
	localparam logic [13:0] GAIN_LUT [32] = '{
		14'h1000, 14'h105f, 14'h10c1, 14'h1125,
		14'h118b, 14'h11f4, 14'h125f, 14'h12cc,
		14'h133d, 14'h13af, 14'h1425, 14'h149d,
		14'h1518, 14'h1595, 14'h1616, 14'h169a,
		14'h1721, 14'h17aa, 14'h1838, 14'h18c8,
		14'h195c, 14'h19f3, 14'h1a8e, 14'h1b2c,
		14'h1bce, 14'h1c74, 14'h1d1d, 14'h1dcb,
		14'h1e7d, 14'h1f32, 14'h1fed, 14'h20ab
	};

	// ----------------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] gain;
		logic       rsvd;
		logic [9:0] offset;
	} acd_gainofs_s;

	typedef struct packed {
		logic [3:0] prbs_en;    // [3] serves output 1
		logic [2:0] pat1;
		logic [2:0] pat2;
		logic       round_sel;
		logic [3:0] corner_k;
		logic       hpf_en;
	} acd_pathpf_s;

	typedef struct packed {
		logic [3:0] rsvd_hi;
		logic [3:0] pair_sel;   // [3] serves converter 1
		logic [2:0] pat3;
		logic [2:0] pat4;
		logic [1:0] rsvd_lo;
	} acd_inspat_s;

	typedef struct packed {
		logic       common_prbs;
		logic [2:0] common_pat;
		logic       rsvd;
		logic       gain_en;
		logic       offset_en;
		logic       per_out_sel;
	} acd_ctrl_s;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} acd_bus_s;

	typedef struct packed {
		logic              valid;
		logic              even;
		logic signed [13:0] data;
	} acd_samp_s;

	typedef struct packed {
		logic       prbs;
		logic [2:0] code;
	} acd_lane_s;

	typedef struct packed {
		acd_gainofs_s                 r14;
		acd_pathpf_s                  r15;
		acd_ctrl_s                    ctrl;
		acd_inspat_s                  r17;
		logic [15:0]                  rdata;
		acd_samp_s                    mid;
		acd_samp_s                    out;
		logic signed [HPF_ACC_W-1:0]  acc;
		acd_lane_s [3:0]              lanes;
	} acd_state_s;

endpackage

// file: rtl/acd_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// [R1] Gain N x 0.2 dB on converter 4 even samples
// [R2] Subtract programmed offset from converter 4 evens
// [R3] Offset is signed, LSB equals 14-bit LSB
// [R4] Per-output pseudo-random enables, bits 15..12
// [R5] Outputs one, two use own pattern codes
// [R6] Outputs three, four use own pattern codes
// [R7] Filter output truncated or rounded by select
// [R8] Corner k from four bits, two to ten
// [R9] Filter bypassed when enable clear, applied when set
// [R10] Pair select bit picks lower or higher pair
// [R11] Shared pattern setting when per-output select off
// ------------------------------------------------------------------
module acd_top (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Register port
	input  wire acd_pkg::acd_bus_s bus_in,
	output      logic [15:0]       bus_rdata,
	// Converter 4 sample stream
	input  wire acd_pkg::acd_samp_s samp_in,
	output      acd_pkg::acd_samp_s samp_out,
	// Serial output pattern settings
	output      acd_pkg::acd_lane_s [3:0] lane_cfg,
	// Input pair selection, [3] is converter 1
	output      logic [3:0]        conv_input_pair_select
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Clip a wide value to the sample range
	function automatic logic signed [13:0] acd_sat(
		input logic signed [31:0] v
	);
		logic signed [13:0] r;
		r = v[13:0];
		if (v > acd_pkg::SAMP_MAX) begin
			r = 14'sh1fff;
		end else if (v < acd_pkg::SAMP_MIN) begin
			r = 14'sh2000;
		end
		return r;
	endfunction

	// Hold the corner setting inside its legal span
	function automatic logic [3:0] acd_k(input logic [3:0] k);
		logic [3:0] r;
		r = k;
		if (k < acd_pkg::K_MIN) begin
			r = acd_pkg::K_MIN;
		end else if (k > acd_pkg::K_MAX) begin
			r = acd_pkg::K_MAX;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	acd_pkg::acd_state_s st_q;
	acd_pkg::acd_state_s st_d;

	// Locals of the next-state process
	logic signed [15:0]                      corr;
	logic signed [15:0]                      offs;
	logic [13:0]                             gfac;
	logic signed [31:0]                      prod;
	logic [3:0]                              kc;
	logic signed [acd_pkg::HPF_ACC_W-1:0]    yf;
	logic signed [acd_pkg::HPF_ACC_W-1:0]    yr;
	logic [2:0]                              codes [4];
	logic                                    k_bad;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.rdata = 16'h0000;
		k_bad = (acd_k(st_q.r15.corner_k) != st_q.r15.corner_k);

		// Register writes
		if (bus_in.wr) begin
			case (bus_in.addr)
				acd_pkg::ADDR_CH4_EVEN: begin
					st_d.r14 = bus_in.wdata;
				end
				acd_pkg::ADDR_PAT_HPF: begin
					st_d.r15 = bus_in.wdata;
				end
				acd_pkg::ADDR_CTRL: begin
					st_d.ctrl = bus_in.wdata[7:0];
				end
				acd_pkg::ADDR_INSEL_PAT: begin
					st_d.r17 = bus_in.wdata;
				end
				default: begin
				end
			endcase
		end

		// Register reads, data stand one cycle later
		if (bus_in.rd) begin
			case (bus_in.addr)
				acd_pkg::ADDR_CH4_EVEN: begin
					st_d.rdata = st_q.r14;
				end
				acd_pkg::ADDR_PAT_HPF: begin
					st_d.rdata = st_q.r15;
				end
				acd_pkg::ADDR_CTRL: begin
					st_d.rdata = {k_bad, 3'h0,
						st_q.lanes[3].prbs, st_q.lanes[2].prbs,
						st_q.lanes[1].prbs, st_q.lanes[0].prbs,
						st_q.ctrl};
				end
				acd_pkg::ADDR_INSEL_PAT: begin
					st_d.rdata = st_q.r17;
				end
				default: begin
					st_d.rdata = 16'h0000;
				end
			endcase
		end

		// Offset correction of even samples, signed 10-bit offset
		corr = {{2{samp_in.data[13]}}, samp_in.data};
		offs = {{6{st_q.r14.offset[9]}}, st_q.r14.offset};   // [R3]
		if (st_q.ctrl.offset_en && samp_in.even) begin
			corr = corr - offs;                               // [R2]
		end

		// Gain in 0.2 dB steps on even samples
		gfac = acd_pkg::GAIN_UNITY;
		if (st_q.ctrl.gain_en && samp_in.even) begin
			gfac = acd_pkg::GAIN_LUT[st_q.r14.gain];          // [R1]
		end
		prod = corr * $signed({1'b0, gfac});
		st_d.mid.valid = samp_in.valid;
		st_d.mid.even  = samp_in.even;
		st_d.mid.data  = acd_sat(prod >>> acd_pkg::GAIN_FRAC);

		// High-pass filter: running DC estimate removed from input
		kc = acd_k(st_q.r15.corner_k);                        // [R8]
		yf = {{2{st_q.mid.data[13]}}, st_q.mid.data,
			{acd_pkg::HPF_FRAC{1'b0}}} - st_q.acc;
		yr = yf;
		if (st_q.r15.round_sel) begin
			yr = yf + acd_pkg::HPF_HALF;                      // [R7]
		end
		st_d.out.valid = st_q.mid.valid;
		st_d.out.even  = st_q.mid.even;
		if (st_q.r15.hpf_en) begin
			st_d.out.data = acd_sat(32'(yr >>> acd_pkg::HPF_FRAC)); // [R7]
			if (st_q.mid.valid) begin
				st_d.acc = st_q.acc + (yf >>> kc);            // [R9]
			end
		end else begin
			st_d.out.data = st_q.mid.data;                    // [R9]
			st_d.acc = '0;
		end

		// Serial output pattern routing
		codes[0] = st_q.r15.pat1;                             // [R5]
		codes[1] = st_q.r15.pat2;                             // [R5]
		codes[2] = st_q.r17.pat3;                             // [R6]
		codes[3] = st_q.r17.pat4;                             // [R6]
		for (int i = 0; i < 4; i++) begin
			if (st_q.ctrl.per_out_sel) begin
				st_d.lanes[i].prbs = st_q.r15.prbs_en[3 - i]; // [R4]
				st_d.lanes[i].code = codes[i];                // [R5] [R6]
			end else begin
				st_d.lanes[i].prbs = st_q.ctrl.common_prbs;   // [R11]
				st_d.lanes[i].code = st_q.ctrl.common_pat;    // [R11]
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q      <= '0;
			st_q.r14  <= acd_pkg::REG_RESET;
			st_q.r15  <= acd_pkg::REG_RESET;                  // [R9]
			st_q.r17  <= acd_pkg::REG_RESET;
			st_q.ctrl <= acd_pkg::CTRL_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from flops
	// ----------------------------------------------------------------
	assign bus_rdata              = st_q.rdata;
	assign samp_out               = st_q.out;
	assign lane_cfg               = st_q.lanes;
	assign conv_input_pair_select = st_q.r17.pair_sel;    // [R10]

endmodule // acd_top

// file: tb/acd_top_props.sv
`timescale 1ns/1ps
module acd_props (
	// Clock, reset
	input wire logic                     clk_sys,
	input wire logic                     rst_n,
	// Register port
	input wire acd_pkg::acd_bus_s        bus_in,
	input wire logic [15:0]              bus_rdata,
	// Samples
	input wire acd_pkg::acd_samp_s       samp_in,
	input wire acd_pkg::acd_samp_s       samp_out,
	// Lanes, pair select
	input wire acd_pkg::acd_lane_s [3:0] lane_cfg,
	input wire logic [3:0]               conv_input_pair_select
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic        sel_q, hpf_q, corr_q;
	logic [3:0]  k_q;
	logic [15:0] wd1_q, wd2_q;
	// Shadow control bits and delayed write data
	always_ff @(posedge clk_sys) begin
		wd1_q <= bus_in.wdata;
		wd2_q <= wd1_q;
		if (!rst_n)
			{sel_q, corr_q, k_q, hpf_q} <= '0;
		else if (bus_in.wr && bus_in.addr == 8'h16)
			{sel_q, corr_q} <= {bus_in.wdata[0], |bus_in.wdata[2:1]};
		else if (bus_in.wr && bus_in.addr == 8'h15)
			{k_q, hpf_q} <= bus_in.wdata[4:0];
	end
	// Lone write to one address, under a condition
	sequence s_wr(a, c);
		c && bus_in.wr && bus_in.addr == a ##1 !bus_in.wr;
	endsequence
	property p_pair; bus_in.wr && bus_in.addr == 8'h17
		|=> conv_input_pair_select == wd1_q[11:8]; endproperty
	a_pair: assert property (p_pair) else $error("pair select");
	property p_prbs; s_wr(8'h15, sel_q) |=> {lane_cfg[0].prbs,
		lane_cfg[1].prbs, lane_cfg[2].prbs, lane_cfg[3].prbs} == wd2_q[15:12];
	endproperty
	a_prbs: assert property (p_prbs) else $error("lane prbs");
	property p_pat12; s_wr(8'h15, sel_q) |=> lane_cfg[0].code == wd2_q[11:9]
		&& lane_cfg[1].code == wd2_q[8:6]; endproperty
	a_pat12: assert property (p_pat12) else $error("lane 1-2 code");
	property p_pat34; s_wr(8'h17, sel_q) |=> lane_cfg[2].code == wd2_q[7:5]
		&& lane_cfg[3].code == wd2_q[4:2]; endproperty
	a_pat34: assert property (p_pat34) else $error("lane 3-4 code");
	property p_common; s_wr(8'h16, !bus_in.wdata[0])
		|=> lane_cfg == {4{wd2_q[7:4]}}; endproperty
	a_common: assert property (p_common) else $error("common lane");
	property p_corner; bus_in.rd && bus_in.addr == 8'h16
		|=> bus_rdata[15] == (k_q < 4'h2 || k_q > 4'ha); endproperty
	a_corner: assert property (p_corner) else $error("corner flag");
	property p_bypass; samp_in.valid && !hpf_q && !corr_q ##1 !hpf_q && !corr_q
		|=> samp_out.valid && samp_out.data == $past(samp_in.data, 2);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass");
	property p_odd; samp_in.valid && !samp_in.even && !hpf_q ##1 !hpf_q
		|=> samp_out.data == $past(samp_in.data, 2); endproperty
	a_odd: assert property (p_odd) else $error("odd sample");
endmodule // acd_props
bind acd_top acd_props u_props (.clk_sys, .rst_n, .bus_in, .bus_rdata,
	.samp_in, .samp_out, .lane_cfg, .conv_input_pair_select);

// file: tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
	logic clk_sys = 0, rst_n = 0, rd_d = 0, ge = 0, oe = 0, he = 0, rnd = 0;
	acd_pkg::acd_bus_s  bus_in = '0;
	acd_pkg::acd_samp_s samp_in = '0, samp_out;
	logic [15:0]        bus_rdata, ex, rv [3];
	logic [31:0]        lf = 32'h8071627a;
	logic [4:0]         g = '0;
	logic signed [9:0]  o = '0;
	int                 k, acc = 0, mismatches = 0, samples_checked = 0;
	logic [15:0]        rq [$];
	logic [15:0]        sq [$];
	logic [7:0]         ad [3] = '{8'h14, 8'h15, 8'h17};
	always #5 clk_sys = ~clk_sys;
	acd_top dut (.clk_sys, .rst_n, .bus_in, .bus_rdata, .samp_in, .samp_out,
		.lane_cfg(), .conv_input_pair_select());
	// Watcher: oldest note against each result
	always @(posedge clk_sys) begin
		if (rd_d) begin
			ex = rq.pop_front();
			`CHK("read", ex, bus_rdata)
		end
		if (samp_out.valid) begin
			ex = sq.pop_front();
			`CHK("sample", {ex[15], ex[13:0]}, {samp_out.even, samp_out.data})
		end
		rd_d = bus_in.rd;
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int sat(input int x);
		return x > 8191 ? 8191 : x < -8192 ? -8192 : x;
	endfunction
	// Reference: offset, gain, then filter
	function automatic logic [15:0] mdl(input logic e,
		input logic signed [13:0] d);
		int v, y;
		v = d;
		y = $rtoi(4096.0 * 10.0 ** (g * 0.01) + 0.5);
		if (oe && e) v = v - o;
		v = sat((ge && e) ? (v * y) >>> 12 : v);
		if (!he) return v[15:0];
		y = (v <<< 10) - acc;
		acc = acc + (y >>> k);
		v = sat((y + (rnd ? 512 : 0)) >>> 10);
		return v[15:0];
	endfunction
	// Register access: write, or read with expected data
	task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d);
		bus_in <= '{a, d, w, !w};
		if (!w) rq.push_back(d);
		@(posedge clk_sys);
		bus_in <= '0;
		@(posedge clk_sys);
	endtask
	// Back-to-back random samples
	task automatic burst(input int n);
		repeat (n) begin
			lf = nx(lf);
			samp_in <= '{1'b1, lf[20], lf[13:0]};
			ex = mdl(lf[20], lf[13:0]);
			sq.push_back({lf[20], ex[14:0]});
			@(posedge clk_sys);
		end
		samp_in <= '0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic end_sim;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		foreach (ad[i]) op(0, ad[i], 16'h0000);
		op(1, 8'h16, 16'h0001);
		foreach (ad[i]) begin
			lf = nx(lf);
			rv[i] = lf[15:0];
			// Keep must-write-0 bits clear and corner k legal
			if (i == 0) rv[i][10] = 1'b0;
			if (i == 1) rv[i][4:1] = 4'h2 + 4'(lf[19:16] % 9);
			if (i == 2) rv[i] = rv[i] & 16'h0ffc;
			op(1, ad[i], rv[i]);
			op(0, ad[i], rv[i]);
		end
		op(0, 8'h16, {rv[1][4:1] < 4'h2 || rv[1][4:1] > 4'ha, 3'h0,
			rv[1][12], rv[1][13], rv[1][14], rv[1][15], 8'h01});
		op(0, 8'h18, 16'h0000);
		op(0, 8'h13, 16'h0000);
		lf = nx(lf);
		op(1, 8'h16, {8'h00, lf[7:4], 4'h0});
		op(1, 8'h15, 16'h0000);
		burst(8);
		// Corrections: random, then full gain and most negative offset
		for (int i = 0; i < 2; i++) begin
			lf = nx(lf);
			{g, o} = i ? {5'h1f, 10'h200} : {lf[15:11], lf[9:0]};
			op(1, 8'h14, {g, 1'b0, o});
			op(1, 8'h16, 16'h0006);
			{ge, oe} = 2'b11;
			burst(10);
		end
		// Filter on, truncation then rounding
		for (int r = 0; r < 2; r++) begin
			lf = nx(lf);
			k = 2 + lf[7:0] % 9;
			op(1, 8'h15, {10'h000, r[0], k[3:0], 1'b1});
			{he, rnd} = {1'b1, r[0]};
			burst(12);
		end
		for (int i = 0; i < 20 && rq.size() + sq.size() > 0; i++)
			@(posedge clk_sys);
		if (rq.size() + sq.size() > 0)
			mismatches++;
		end_sim();
	end
endmodule // tb
